// ---- inc/bcd_pkg.sv ----
// constants, types and opcode map shared by the byte core decoder
package bcd_pkg;

	localparam int          PC_W          = 12;
	localparam int          STACK_DEPTH   = 6;
	localparam logic [11:0] PC_RESET      = 12'h000;
	localparam logic [11:0] INT_VEC_RESET = 12'hff0;

	// data-space locations held inside the core
	localparam logic [7:0]  ADDR_PTR_A    = 8'h80;
	localparam logic [7:0]  ADDR_ACC      = 8'hff;
	localparam logic [5:0]  ADDR_PTR_PAGE = 6'h20;

	// opcode groups, upper bits
	localparam logic [3:0]  GRP_CALL      = 4'h8;
	localparam logic [3:0]  GRP_JUMP      = 4'h9;
	localparam logic [3:0]  GRP_BTB       = 4'ha;
	localparam logic [3:0]  GRP_BIT       = 4'hb;
	localparam logic [2:0]  GRP_IND       = 3'h6;
	localparam logic [3:0]  GRP_DIR       = 4'he;
	localparam logic [3:0]  GRP_IMM       = 4'hf;

	// function field, low opcode bits
	localparam logic [3:0]  FN_LOAD       = 4'h0;
	localparam logic [3:0]  FN_STORE      = 4'h1;
	localparam logic [3:0]  FN_AND        = 4'h2;
	localparam logic [3:0]  FN_ADD        = 4'h3;
	localparam logic [3:0]  FN_CP         = 4'h4;
	localparam logic [3:0]  FN_SUB        = 4'h5;
	localparam logic [3:0]  FN_INC        = 4'h6;
	localparam logic [3:0]  FN_NOP        = 4'h6;
	localparam logic [3:0]  FN_DEC        = 4'h7;
	localparam logic [3:0]  FN_CLR        = 4'h8;
	localparam logic [3:0]  FN_COM        = 4'h9;
	localparam logic [3:0]  FN_RLC        = 4'ha;
	localparam logic [3:0]  FN_SLA        = 4'hb;
	localparam logic [3:0]  FN_RET        = 4'hc;
	localparam logic [3:0]  FN_RETI       = 4'hd;
	localparam logic [3:0]  FN_STOP       = 4'he;
	localparam logic [3:0]  FN_WAIT       = 4'hf;

	// instruction lengths in core clock cycles
	localparam int          CYC_SHORT     = 2;
	localparam int          CYC_ALU       = 4;
	localparam int          CYC_BTB       = 5;

	typedef enum logic [2:0] {st_fetch, st_decode, st_arg2, st_exec, st_tail, st_halt} bcd_state_t;

	typedef struct packed {
		logic zero;
		logic carry;
	} bcd_flags_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       we;
	} bcd_dbus_t;

	localparam bcd_flags_t  FLAGS_RESET   = '{zero: 1'b0, carry: 1'b0};

endpackage : bcd_pkg

// ---- rtl/bcd_core.sv ----
// byte core: instruction decode, operand addressing, return stack and execution
`timescale 1ns/10ps

module bcd_core
	import bcd_pkg::*;
#(
	parameter logic [11:0] INT_VEC     = INT_VEC_RESET,
	parameter int          STACK_CELLS = STACK_DEPTH
)
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// program space
	output logic [11:0]     prog_addr,
	input  wire logic [7:0] prog_data,
	// data space
	output bcd_dbus_t       dbus,
	input  wire logic [7:0] data_rdata,
	// interrupt and power
	input  wire logic       int_req,
	output logic            int_ack,
	input  wire logic       watchdog_sel,
	output logic            wait_mode,
	output logic            stop_mode,
	output logic            bad_opcode
);

	bcd_state_t  st;
	logic [11:0] pc;
	logic [7:0]  op;
	logic [7:0]  arg1;
	logic [7:0]  arg2;
	logic [7:0]  opnd;
	logic [7:0]  acc;
	logic [7:0]  xr [4];
	bcd_flags_t  flg;
	bcd_flags_t  flg_save;
	logic        int_en;
	logic [11:0] stack [STACK_CELLS];
	logic [2:0]  cyc_cnt;

	logic        is_rel;
	logic        is_call;
	logic        is_jp;
	logic        is_btb;
	logic        is_bit;
	logic        is_ind;
	logic        is_short;
	logic        is_dir;
	logic        is_imm;
	logic [3:0]  fn;
	logic        undef_op;
	logic        inh_op;
	logic        two_cyc;
	logic [1:0]  ins_len;
	logic [3:0]  rel_span;
	logic        rel_cond;
	logic        bit_val;
	logic [11:0] ext_addr;
	logic [7:0]  ptr_val;
	logic [11:0] next_pc;
	logic [11:0] load_pc;
	logic [11:0] push_val;
	logic        done;
	logic        halting;
	logic        take_int;
	logic        push;
	logic        pop;
	logic [7:0]  rd_val;
	logic        wr_int;
	logic [7:0]  src;
	logic [7:0]  res;
	logic [7:0]  mask;
	logic [8:0]  wide;
	logic        wr_en;
	logic [7:0]  wr_addr;
	bcd_flags_t  next_flg;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	always_comb
	begin
		is_rel   = (op[7] == 1'b0);
		is_call  = (op[7:4] == GRP_CALL);
		is_jp    = (op[7:4] == GRP_JUMP);
		is_btb   = (op[7:4] == GRP_BTB);
		is_bit   = (op[7:4] == GRP_BIT);
		is_ind   = (op[7:5] == GRP_IND) && !op[3];
		is_short = (op[7:5] == GRP_IND) && op[3];
		is_dir   = (op[7:4] == GRP_DIR);
		is_imm   = (op[7:4] == GRP_IMM);
		if (is_short)
			fn = {1'b0, op[4], op[4], op[2]};
		else if (is_ind)
			fn = {1'b0, op[2:0]};
		else
			fn = op[3:0];
		undef_op = (is_dir && (fn > FN_CLR)) || (is_imm && (fn > FN_NOP) && (fn < FN_COM));
		inh_op   = is_imm && ((fn == FN_NOP) || (fn >= FN_RET));
		two_cyc  = is_rel || inh_op || undef_op;
		if (is_btb || (is_imm && (fn == FN_STORE)))
			ins_len = 2'h3;
		else if (is_rel || is_ind || is_short || inh_op || undef_op || (is_imm && (fn >= FN_COM)))
			ins_len = 2'h1;
		else
			ins_len = 2'h2;
	end

	// branch targets and next address
	always_comb
	begin
		rel_span = op[3:0];
		// type in top bits picks the flag and its sense
		rel_cond = ((op[6] ? flg.carry : flg.zero) == op[5]);
		bit_val  = opnd[op[2:0]];
		ext_addr = {op[3:0], arg1};
		ptr_val  = xr[{1'b0, op[4]}];
		next_pc  = pc + {10'h000, ins_len};
		if (is_rel && rel_cond)
			next_pc = op[4] ? (pc - {8'h00, rel_span}) : (pc + 12'h001 + {8'h00, rel_span});
		else if (is_call || is_jp)
			next_pc = ext_addr;
		else if (is_btb && (bit_val == op[3]))
			next_pc = pc + 12'h001 + {{4{arg2[7]}}, arg2};
		else if (inh_op && ((fn == FN_RET) || (fn == FN_RETI)))
			next_pc = stack[0];
	end

	always_comb
	begin
		done     = ((st == st_decode) && two_cyc) || ((st == st_exec) && !is_btb) || (st == st_tail);
		halting  = done && inh_op && ((fn == FN_STOP) || (fn == FN_WAIT));
		take_int = int_en && int_req && ((st == st_halt)
			|| (done && !halting && !is_call && !(inh_op && (fn >= FN_RET))));
		push     = (done && is_call) || take_int;
		pop      = done && inh_op && ((fn == FN_RET) || (fn == FN_RETI));
		if (take_int)
			push_val = (st == st_halt) ? pc : next_pc;
		else
			push_val = pc + {10'h000, ins_len};
		if (take_int)
			load_pc = INT_VEC;
		else if (st == st_halt)
			load_pc = pc;
		else
			load_pc = next_pc;
	end

	// data space read, core registers overlay memory
	always_comb
	begin
		if (dbus.addr == ADDR_ACC)
			rd_val = acc;
		else if (dbus.addr[7:2] == ADDR_PTR_PAGE)
			rd_val = xr[dbus.addr[1:0]];
		else
			rd_val = data_rdata;
		wr_int = (wr_addr == ADDR_ACC) || (wr_addr[7:2] == ADDR_PTR_PAGE);
	end

	// execute stage
	always_comb
	begin
		src      = is_imm ? arg1 : opnd;
		mask     = 8'h01 << op[2:0];
		res      = 8'h00;
		wide     = 9'h000;
		wr_en    = 1'b0;
		wr_addr  = dbus.addr;
		next_flg = flg;
		if (is_bit)
		begin
			res            = op[3] ? (opnd | mask) : (opnd & ~mask);
			wr_en          = 1'b1;
			next_flg.carry = bit_val;
		end
		else if (is_btb)
		begin
			next_flg.carry = bit_val;
		end
		else if (is_imm && (fn == FN_STORE))
		begin
			res   = arg2;
			wr_en = 1'b1;
		end
		else if (is_ind || is_short || is_dir || is_imm)
		begin
			case (fn)
				FN_LOAD:
				begin
					res           = src;
					wr_en         = 1'b1;
					wr_addr       = ADDR_ACC;
					next_flg.zero = (res == 8'h00);
				end
				FN_STORE:
				begin
					res           = acc;
					wr_en         = 1'b1;
					next_flg.zero = (res == 8'h00);
				end
				FN_AND:
				begin
					res      = acc & src;
					wr_en    = 1'b1;
					wr_addr  = ADDR_ACC;
					next_flg = '{zero: (res == 8'h00), carry: 1'b0};
				end
				FN_ADD, FN_CP, FN_SUB:
				begin
					wide     = (fn == FN_ADD) ? ({1'b0, acc} + {1'b0, src}) : ({1'b0, acc} - {1'b0, src});
					res      = wide[7:0];
					wr_en    = (fn != FN_CP);
					wr_addr  = ADDR_ACC;
					next_flg = '{zero: (res == 8'h00), carry: wide[8]};
				end
				FN_INC, FN_DEC:
				begin
					res           = (fn == FN_INC) ? (src + 8'h01) : (src - 8'h01);
					wr_en         = 1'b1;
					next_flg.zero = (res == 8'h00);
				end
				FN_CLR:
				begin
					wr_en = 1'b1;
					if (wr_addr == ADDR_ACC)
						next_flg = '{zero: 1'b1, carry: 1'b0};
				end
				FN_COM, FN_RLC, FN_SLA:
				begin
					if (fn == FN_COM)
						wide = {acc[7], ~acc};
					else
						wide = {acc, (fn == FN_RLC) ? flg.carry : 1'b0};
					res      = wide[7:0];
					wr_en    = 1'b1;
					wr_addr  = ADDR_ACC;
					next_flg = '{zero: (res == 8'h00), carry: wide[8]};
				end
				default:
				begin
					wr_en = 1'b0;
				end
			endcase
		end
	end

	// sequencer, program counter and fetch address
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st        <= st_fetch;
			pc        <= PC_RESET;
			prog_addr <= PC_RESET;
			op        <= 8'h00;
			arg1      <= 8'h00;
			arg2      <= 8'h00;
			opnd      <= 8'h00;
		end
		else
		begin
			case (st)
				st_fetch:
				begin
					op        <= prog_data;
					prog_addr <= pc + 12'h001;
					st        <= st_decode;
				end
				st_decode:
				begin
					arg1      <= prog_data;
					prog_addr <= pc + 12'h002;
					if (two_cyc)
						st <= halting ? st_halt : st_fetch;
					else
						st <= st_arg2;
				end
				st_arg2:
				begin
					arg2 <= prog_data;
					opnd <= rd_val;
					st   <= st_exec;
				end
				st_exec:
				begin
					st <= is_btb ? st_tail : st_fetch;
				end
				st_tail:
				begin
					st <= st_fetch;
				end
				st_halt:
				begin
					if (int_req)
						st <= st_fetch;
				end
				default:
				begin
					st <= st_fetch;
				end
			endcase
			if (done || ((st == st_halt) && int_req))
			begin
				pc        <= load_pc;
				prog_addr <= load_pc;
			end
		end
	end

	// data bus address and external writes
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			dbus <= '0;
		else
		begin
			dbus.we <= 1'b0;
			if (st == st_decode)
			begin
				if (is_dir || is_bit || is_btb || (is_imm && (fn == FN_STORE)))
					dbus.addr <= prog_data;
				else if (is_ind)
					dbus.addr <= ptr_val;
				else if (is_short)
					dbus.addr <= {ADDR_PTR_PAGE, op[1:0]};
			end
			if ((st == st_exec) && wr_en && !wr_int)
			begin
				dbus.we    <= 1'b1;
				dbus.wdata <= res;
			end
		end
	end

	// accumulator, pointers and scratch registers
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			acc <= 8'h00;
			for (int i = 0; i < 4; i++)
				xr[i] <= 8'h00;
		end
		else if ((st == st_exec) && wr_en && wr_int)
		begin
			if (wr_addr == ADDR_ACC)
				acc <= res;
			else
				xr[wr_addr[1:0]] <= res;
		end
	end

	// flags and interrupt enable
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			flg      <= FLAGS_RESET;
			flg_save <= FLAGS_RESET;
			int_en   <= 1'b1;
		end
		else
		begin
			if (st == st_exec)
				flg <= next_flg;
			if (pop && (fn == FN_RETI))
			begin
				flg    <= flg_save;
				int_en <= 1'b1;
			end
			if (take_int)
			begin
				flg_save <= (st == st_exec) ? next_flg : flg;
				int_en   <= 1'b0;
			end
		end
	end

	// return stack, oldest cell lost on overflow
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < STACK_CELLS; i++)
				stack[i] <= 12'h000;
		end
		else if (push)
		begin
			stack[0] <= push_val;
			for (int i = 1; i < STACK_CELLS; i++)
				stack[i] <= stack[i - 1];
		end
		else if (pop)
		begin
			for (int i = 0; i < STACK_CELLS - 1; i++)
				stack[i] <= stack[i + 1];
		end
	end

	// status outputs and power modes
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			int_ack    <= 1'b0;
			bad_opcode <= 1'b0;
			wait_mode  <= 1'b0;
			stop_mode  <= 1'b0;
		end
		else
		begin
			int_ack    <= take_int;
			bad_opcode <= (st == st_decode) && undef_op;
			if (halting)
			begin
				stop_mode <= (fn == FN_STOP) && !watchdog_sel;
				wait_mode <= (fn == FN_WAIT) || watchdog_sel;
			end
			else if ((st == st_halt) && int_req)
			begin
				stop_mode <= 1'b0;
				wait_mode <= 1'b0;
			end
		end
	end

	// cycles since instruction start, checked below
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			cyc_cnt <= 3'h0;
		else if (done || (st == st_halt))
			cyc_cnt <= 3'h0;
		else
			cyc_cnt <= cyc_cnt + 3'h1;
	end

	sequence seq_alu_path;
		(st == st_arg2) ##1 (st == st_exec) ##1 (st == st_fetch);
	endsequence

	sequence seq_btb_path;
		(st == st_arg2) ##1 (st == st_exec) ##1 (st == st_tail) ##1 (st == st_fetch);
	endsequence

	alu_four_cyc_a: assert property ((st == st_decode) && !two_cyc && !is_btb |=> seq_alu_path)
		else $error("four-cycle instruction took another path");
	alu_cycle_count_a: assert property (done && !two_cyc && !is_btb |-> cyc_cnt == 3'(CYC_ALU - 1))
		else $error("four-cycle instruction ended at wrong count");
	btb_path_a: assert property ((st == st_decode) && is_btb |=> seq_btb_path)
		else $error("bit test branch did not take five cycles");
	rel_fall_a: assert property ((st == st_decode) && is_rel && !rel_cond && !take_int |=> pc == $past(pc) + 12'h001)
		else $error("untaken branch did not advance one byte");
	rel_back_a: assert property ((st == st_decode) && is_rel && rel_cond && op[4] && !take_int
		|=> pc == $past(pc) - {8'h00, $past(rel_span)})
		else $error("backward branch target wrong");
	call_push_a: assert property (done && is_call |=> stack[0] == $past(pc) + 12'h002)
		else $error("call pushed wrong return address");
	ext_target_a: assert property (done && (is_call || is_jp) && !take_int |=> pc == $past(ext_addr))
		else $error("extended target wrong");
	bit_carry_a: assert property ((st == st_exec) && is_bit |=> flg.carry == $past(bit_val))
		else $error("bit op did not copy old bit to carry");
	btb_flags_a: assert property ((st == st_exec) && is_btb
		|=> (flg.carry == $past(bit_val)) && $stable(flg.zero))
		else $error("bit test branch flags wrong");
	ld_flags_a: assert property ((st == st_exec) && (is_dir || is_ind || is_short) && (fn <= FN_STORE)
		|=> $stable(flg.carry) && (flg.zero == ($past(res) == 8'h00)))
		else $error("move_byte flags wrong");
	ldi_flags_a: assert property ((st == st_exec) && is_imm && (fn == FN_STORE) |=> $stable(flg))
		else $error("move_immediate to memory changed flags");
	ind_pointer_a: assert property ((st == st_decode) && is_ind |=> dbus.addr == $past(ptr_val))
		else $error("indirect address not taken from pointer");
	stop_wait_a: assert property (halting && (fn == FN_STOP) && watchdog_sel |=> wait_mode && !stop_mode)
		else $error("stop not turned into wait");

endmodule : bcd_core

// ---- sim/bcd_core_tb.sv ----
// self-checking bench for the byte core decoder
`timescale 1ns/10ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
	$display("ERROR %0t: got %h exp %h", $time, got, exp); end end

module bcd_core_tb
	import bcd_pkg::*;
();

	// clock and reset
	logic        clk;
	logic        nrst;
	// core ports
	logic [11:0] prog_addr;
	logic [7:0]  prog_data;
	bcd_dbus_t   dbus;
	logic [7:0]  data_rdata;
	logic        int_req;
	logic        int_ack;
	logic        watchdog_sel;
	logic        wait_mode;
	logic        stop_mode;
	logic        bad_opcode;
	// memories and logs
	logic [7:0]  rom [0:4095];
	logic [7:0]  ram [0:255];
	int          wcnt [0:255];
	int          wcyc [$];
	logic [7:0]  wadr [$];
	logic [7:0]  wdat [$];
	int          exa [10];
	int          exz [10];
	int          exc [10];
	int          cyc;
	int          bad_n;
	int          ack_n;
	int          pp;
	int          error_cnt = 0;
	int          tests_run = 0;

	// memories answer in the same cycle
	assign prog_data  = rom[prog_addr];
	assign data_rdata = ram[dbus.addr];

	bcd_core dut_u (
		.clk          (clk),
		.nrst         (nrst),
		.prog_addr    (prog_addr),
		.prog_data    (prog_data),
		.dbus         (dbus),
		.data_rdata   (data_rdata),
		.int_req      (int_req),
		.int_ack      (int_ack),
		.watchdog_sel (watchdog_sel),
		.wait_mode    (wait_mode),
		.stop_mode    (stop_mode),
		.bad_opcode   (bad_opcode)
	);

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// edges since reset release
	always @(posedge clk)
	begin
		if (!nrst)
			cyc <= 0;
		else
			cyc <= cyc + 1;
	end

	// data ram writes and pulse counts, sampled mid-cycle
	always @(negedge clk)
	begin
		if (nrst === 1'b1 && dbus.we === 1'b1)
		begin
			ram[dbus.addr] = dbus.wdata;
			wcnt[dbus.addr]++;
			wcyc.push_back(cyc);
			wadr.push_back(dbus.addr);
			wdat.push_back(dbus.wdata);
		end
		if (nrst === 1'b1 && bad_opcode === 1'b1)
			bad_n++;
		if (nrst === 1'b1 && int_ack === 1'b1)
			ack_n++;
	end

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	task automatic emit(input logic [7:0] b);
		rom[pp] = b;
		pp++;
	endtask : emit

	// bytes go out most significant first
	task automatic put(input int n, input logic [127:0] v);
		for (int i = n - 1; i >= 0; i--)
			emit(v[i*8 +: 8]);
	endtask : put

	task automatic hold_reset;
		@(posedge clk);
		nrst         <= 1'b0;
		int_req      <= 1'b0;
		watchdog_sel <= 1'b0;
		for (int i = 0; i < 4096; i++)
			rom[i] = 8'hf6;
		for (int i = 0; i < 256; i++)
		begin
			ram[i]  = 8'h00;
			wcnt[i] = 0;
		end
		wcyc.delete();
		wadr.delete();
		wdat.delete();
		bad_n = 0;
		ack_n = 0;
		pp    = 0;
	endtask : hold_reset

	task automatic release_reset;
		repeat (5) @(posedge clk);
		`CHK(prog_addr, 12'h000)
		`CHK(dbus, 17'h00000)
		`CHK({int_ack, bad_opcode, wait_mode, stop_mode}, 4'h0)
		nrst <= 1'b1;
	endtask : release_reset

	task automatic run(input int n);
		repeat (n) @(negedge clk);
	endtask : run

	task automatic chk_wr(input int i, input logic [7:0] a, input logic [7:0] d, input int c);
		`CHK(wadr[i], a)
		`CHK(wdat[i], d)
		`CHK(wcyc[i], c)
	endtask : chk_wr

	task automatic t_move;
		hold_reset();
		ram[8'h5a] = 8'h3c;
		put(7, 56'hf05ae140f141a5);
		put(8, 64'hccf000c0e142900d);
		release_reset();
		run(40);
		`CHK(wcyc.size(), 3)
		chk_wr(0, 8'h40, 8'h5a, 8);
		chk_wr(1, 8'h41, 8'ha5, 12);
		chk_wr(2, 8'h42, 8'h3c, 28);
		$display("t_move done");
	endtask : t_move

	// ldi, op, then zero, carry and result each leave a mark in ram
	task automatic alu_case(input logic [7:0] k, input logic [7:0] a, input logic [15:0] op,
		input int ea, input int ez, input int ec);
		put(2, {8'hf0, a});
		put(2, op);
		put(8, {8'h02, 8'he1, 8'h20 + k, 8'h42, 8'he1, 8'h30 + k, 8'he1, 8'h10 + k});
		exa[k] = ea;
		exz[k] = ez;
		exc[k] = ec;
	endtask : alu_case

	task automatic t_alu;
		hold_reset();
		ram[8'h51] = 8'hff;
		ram[8'h53] = 8'h01;
		ram[8'h59] = 8'h55;
		alu_case(0, 8'hf0, 16'hf320, 8'h10, 0, 1);
		alu_case(1, 8'h11, 16'he651, 8'h11, 1, 1);
		alu_case(2, 8'hff, 16'hf200, 8'h00, 1, 0);
		alu_case(3, 8'h22, 16'he753, 8'h22, 1, 0);
		alu_case(4, 8'h05, 16'hf506, 8'hff, 0, 1);
		alu_case(5, 8'h07, 16'hf407, 8'h07, 1, 0);
		alu_case(6, 8'h81, 16'hfaf6, 8'h02, 0, 1);
		alu_case(7, 8'h80, 16'hfbf6, 8'h00, 1, 1);
		alu_case(8, 8'h7f, 16'hf9f6, 8'h80, 0, 0);
		alu_case(9, 8'h00, 16'he859, 8'h00, 1, 0);
		put(2, 16'h9078);
		release_reset();
		run(320);
		for (int k = 0; k < 10; k++)
		begin
			`CHK(int'(ram[8'h10 + k]), exa[k])
			`CHK(wcnt[8'h20 + k], exz[k])
			`CHK(wcnt[8'h30 + k], exc[k])
		end
		`CHK({ram[8'h51], ram[8'h53], ram[8'h59]}, 24'h000000)
		$display("t_alu done");
	endtask : t_alu

	task automatic t_bits;
		hold_reset();
		ram[8'h60] = 8'h0f;
		put(10, 80'hbc6042e131b06042e132);
		put(10, 80'ha96004e133a06004e134);
		put(10, 80'ha86004e13562e136901c);
		release_reset();
		run(80);
		`CHK(ram[8'h60], 8'h1e)
		`CHK(wcnt[8'h31], 0)
		`CHK(wcnt[8'h32], 1)
		`CHK(wcnt[8'h33] + wcnt[8'h34], 0)
		`CHK(wcnt[8'h35], 1)
		`CHK(wcnt[8'h36], 1)
		$display("t_bits done");
	endtask : t_bits

	task automatic t_flow;
		hold_reset();
		put(14, 112'hf003cce671dc1383a0f0002fe67e);
		pp = 12'h01b;
		put(4, 32'he67f901d);
		// six nested subroutines fill the return stack
		for (logic [7:0] i = 0; i < 6; i++)
		begin
			pp = 12'h3a0 + {i, 4'h0};
			put(2, {8'he6, 8'h72 + i});
			if (i < 5)
				put(2, {8'h83, 8'hb0 + {i[3:0], 4'h0}});
			emit(8'hfc);
		end
		release_reset();
		run(200);
		`CHK(ram[8'h71], 8'h03)
		`CHK(wcnt[8'h71], 3)
		for (int i = 8'h72; i < 8'h78; i++)
			`CHK(wcnt[i], 1)
		`CHK(wcnt[8'h7e], 0)
		`CHK(wcnt[8'h7f], 1)
		$display("t_flow done");
	endtask : t_flow

	task automatic irq;
		@(posedge clk);
		int_req      <= 1'b1;
		watchdog_sel <= 1'b0;
		for (int i = 0; i < 20 && int_ack !== 1'b1; i++)
			@(negedge clk);
		`CHK(int_ack, 1'b1)
		@(posedge clk);
		int_req <= 1'b0;
	endtask : irq

	task automatic t_halt;
		hold_reset();
		watchdog_sel <= 1'b1;
		put(7, 56'hf7fee679fe9005);
		pp = 12'hff0;
		put(3, 24'he678fd);
		release_reset();
		run(20);
		`CHK(bad_n, 1)
		`CHK({wait_mode, stop_mode}, 2'b10)
		irq();
		run(40);
		`CHK(wcnt[8'h78] + wcnt[8'h79], 2)
		`CHK({wait_mode, stop_mode}, 2'b01)
		irq();
		run(40);
		`CHK(wcnt[8'h78], 2)
		`CHK({wait_mode, stop_mode, ack_n, bad_n}, {2'b00, 32'd2, 32'd1})
		$display("t_halt done");
	endtask : t_halt

	initial
	begin
		nrst         = 1'b0;
		int_req      = 1'b0;
		watchdog_sel = 1'b0;
		pp           = 0;
		t_move();
		t_alu();
		t_bits();
		t_flow();
		t_halt();
		wrap_up();
	end

	// cuts a hang short well past the expected run length
	initial
	begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		$display("ERROR %0t: watchdog expired", $time);
		wrap_up();
	end

endmodule : bcd_core_tb
